// file: verilog/ums_defines.svh
// offsets, bit positions, reset values and counts for the modem/status/interrupt registers
`ifndef UMS_DEFINES_SVH
`define UMS_DEFINES_SVH

`define UMS_A_RX_TX      3'h0
`define UMS_A_INT_EN     3'h1
`define UMS_A_INT_ID     3'h2
`define UMS_A_MODEM_CTL  3'h4
`define UMS_A_LINE_STAT  3'h5
`define UMS_A_MODEM_STAT 3'h6

`define UMS_MC_DTR       0
`define UMS_MC_RTS       1
`define UMS_MC_FRDY      2
`define UMS_MC_IRQ_EN    3
`define UMS_MC_LOOP      4
`define UMS_MC_XON_ANY   5
`define UMS_MC_TLR_EN    6
`define UMS_MC_DIV4      7

`define UMS_IE_RX_DATA   0
`define UMS_IE_TX_EMPTY  1
`define UMS_IE_LINE      2
`define UMS_IE_MODEM     3
`define UMS_IE_XOFF      5
`define UMS_IE_RTS       6
`define UMS_IE_CTS       7

`define UMS_MC_RESET     8'h00
`define UMS_IE_RESET     8'h00
`define UMS_RD_RESET     8'h00
`define UMS_FIFO_DEPTH   64

`endif

// file: verilog/ums_pkg.sv
// types shared by the modem/status/interrupt register block
package ums_pkg;

  // modem input levels, active high, ordered as the status delta bits
  typedef struct packed {
    logic cd;
    logic ri;
    logic dsr;
    logic cts;
  } ums_modem_s;

  // error bits of the character at the head of the receive fifo
  typedef struct packed {
    logic brk;
    logic frm;
    logic par;
  } ums_head_err_s;

  // raw interrupt sources from the datapath
  typedef struct packed {
    logic rx_timeout;
    logic rx_data;
    logic xoff_seen;
    logic cts_rise;
    logic rts_rise;
  } ums_int_src_s;

  // identification codes, bits 5:0 of the identification register
  typedef enum logic [5:0] {
    UMS_IID_NONE  = 6'b00_0001,
    UMS_IID_LINE  = 6'b00_0110,
    UMS_IID_RXTO  = 6'b00_1100,
    UMS_IID_RXDAT = 6'b00_0100,
    UMS_IID_TXE   = 6'b00_0010,
    UMS_IID_MODEM = 6'b00_0000,
    UMS_IID_XOFF  = 6'b01_0000,
    UMS_IID_FLOW  = 6'b10_0000
  } ums_iid_e;

endpackage : ums_pkg

// file: verilog/ums_modem_detect.sv
// change detector for the four modem status inputs, ri flagged on its rising edge only
`timescale 1ns/1ps
module ums_modem_detect
  import ums_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input ums_pkg::ums_modem_s lvl,
  input wire logic rd_clr,
  output logic [3:0] delta
);
  logic [3:0] cur;
  logic [3:0] prev_r;
  logic prev_vld_r;
  logic [3:0] hit;

  assign cur = lvl;

  // first sample after reset only primes the history
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prev_r <= 4'h0;
      prev_vld_r <= 1'b0;
    end else if (ce) begin
      prev_r <= cur;
      prev_vld_r <= 1'b1;
    end
  end

  genvar i;
  for (i = 0; i < 4; i++) begin : g_bit
    if (i == 2) begin : g_rise
      assign hit[i] = prev_vld_r & cur[i] & ~prev_r[i];
    end else begin : g_any
      assign hit[i] = prev_vld_r & (cur[i] ^ prev_r[i]);
    end
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        delta[i] <= 1'b0;
      end else if (ce) begin
        if (hit[i]) begin
          delta[i] <= 1'b1;
        end else if (rd_clr) begin
          delta[i] <= 1'b0;
        end
      end
    end
  end

  chk_set_beats_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    ce && rd_clr && (|hit) |=> (delta & $past(hit)) == $past(hit))
    else $error("modem change lost to read clear");

endmodule : ums_modem_detect

// file: verilog/ums_regs.sv
// per-channel modem control, modem/line status and interrupt registers
`timescale 1ns/1ps
`include "ums_defines.svh"
module ums_regs #(
  parameter int FIFO_DEPTH = `UMS_FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [2:0] addr,
  input wire logic std_bank,
  input wire logic rd_stb,
  input wire logic wr_stb,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic rx_pop,
  output logic tx_push,
  input wire logic enh_en,
  input wire logic fifo_en,
  input wire logic auto_rts_en,
  input wire logic flow_rts_b,
  input wire logic rx_not_empty,
  input wire logic rx_overrun,
  input ums_pkg::ums_head_err_s rx_head_err,
  input wire logic rx_push,
  input wire logic rx_push_err,
  input wire logic rx_fifo_clear,
  input wire logic thr_empty,
  input wire logic tx_all_empty,
  input ums_pkg::ums_int_src_s int_src,
  input wire logic clock_prescale_select_pin,
  input wire logic cts_b,
  input wire logic dsr_b,
  input wire logic ri_b,
  input wire logic cd_b,
  output logic dtr_b,
  output logic rts_b,
  input wire logic tx_serial,
  input wire logic rx_pin,
  output logic tx_pin,
  output logic rx_serial,
  output logic irq,
  output logic irq_oe,
  output logic fifo_ready_en,
  output logic xon_any_en,
  output logic thresh_access_en,
  output logic prescale_div4,
  output logic loopback
);
  import ums_pkg::*;

  localparam int CNT_W = $clog2(FIFO_DEPTH + 1);

  if (FIFO_DEPTH < 1 || FIFO_DEPTH > 256) begin : g_bad_depth
    $error("FIFO_DEPTH out of range");
  end

  function automatic logic hit(input logic [2:0] a, input logic [2:0] code, input logic bank);
    hit = bank && (a == code);
  endfunction : hit

  logic [7:0] mcr_r;
  logic [7:0] ier_r;
  logic rst_seen_r;
  logic [CNT_W-1:0] err_cnt_r;
  logic empty_rd_r;
  logic thr_empty_q_r;
  logic txe_pend_r;
  logic xoff_pend_r;
  logic flow_pend_r;
  logic [3:0] delta;
  ums_modem_s msr_lvl;
  ums_iid_e iid;
  logic lsr_err_sum;
  logic [7:0] lsr_val;
  logic [6:0] pend;

  logic rd_rx;
  logic rd_iid;
  logic rd_msr;
  logic wr_tx;
  logic wr_ier;
  logic wr_mcr;

  assign rd_rx = ce && rd_stb && hit(addr, `UMS_A_RX_TX, std_bank);
  assign rd_iid = ce && rd_stb && hit(addr, `UMS_A_INT_ID, std_bank);
  assign rd_msr = ce && rd_stb && hit(addr, `UMS_A_MODEM_STAT, std_bank);
  assign wr_tx = ce && wr_stb && hit(addr, `UMS_A_RX_TX, std_bank);
  assign wr_ier = ce && wr_stb && hit(addr, `UMS_A_INT_EN, std_bank);
  assign wr_mcr = ce && wr_stb && hit(addr, `UMS_A_MODEM_CTL, std_bank);

  // ---- modem control ----
  // divide select from pin after reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mcr_r <= `UMS_MC_RESET;
      rst_seen_r <= 1'b0;
    end else if (ce) begin
      rst_seen_r <= 1'b1;
      if (!rst_seen_r) begin
        mcr_r[`UMS_MC_DIV4] <= ~clock_prescale_select_pin;
      end else if (wr_mcr) begin
        mcr_r[4:0] <= wdata[4:0];
        if (enh_en) begin
          mcr_r[7:5] <= wdata[7:5];
        end
      end
    end
  end

  assign xon_any_en = mcr_r[`UMS_MC_XON_ANY];
  assign thresh_access_en = mcr_r[`UMS_MC_TLR_EN];
  assign prescale_div4 = mcr_r[`UMS_MC_DIV4];
  assign loopback = mcr_r[`UMS_MC_LOOP];

  // DTR pin, parked inactive in loopback
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dtr_b <= 1'b1;
    end else if (ce) begin
      dtr_b <= mcr_r[`UMS_MC_LOOP] | ~mcr_r[`UMS_MC_DTR];
    end
  end

  // RTS pin, parked inactive in loopback, else hardware flow owns it when enabled
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rts_b <= 1'b1;
    end else if (ce) begin
      if (mcr_r[`UMS_MC_LOOP]) begin
        rts_b <= 1'b1;
      end else if (auto_rts_en) begin
        rts_b <= flow_rts_b;
      end else begin
        rts_b <= ~mcr_r[`UMS_MC_RTS];
      end
    end
  end

  // serial loopback, line held idle meanwhile
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_pin <= 1'b1;
      rx_serial <= 1'b1;
    end else if (ce) begin
      tx_pin <= mcr_r[`UMS_MC_LOOP] | tx_serial;
      rx_serial <= mcr_r[`UMS_MC_LOOP] ? tx_serial : rx_pin;
    end
  end

  // fifo ready register gate, blocked by loopback
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fifo_ready_en <= 1'b0;
      irq_oe <= 1'b0;
    end else if (ce) begin
      fifo_ready_en <= mcr_r[`UMS_MC_FRDY] & ~mcr_r[`UMS_MC_LOOP];
      irq_oe <= mcr_r[`UMS_MC_IRQ_EN];
    end
  end

  // ---- modem status ----
  // loopback or inverted pins
  always_comb begin
    if (mcr_r[`UMS_MC_LOOP]) begin
      msr_lvl.cts = mcr_r[`UMS_MC_RTS];
      msr_lvl.dsr = mcr_r[`UMS_MC_DTR];
      msr_lvl.ri = mcr_r[`UMS_MC_FRDY];
      msr_lvl.cd = mcr_r[`UMS_MC_IRQ_EN];
    end else begin
      msr_lvl.cts = ~cts_b;
      msr_lvl.dsr = ~dsr_b;
      msr_lvl.ri = ~ri_b;
      msr_lvl.cd = ~cd_b;
    end
  end

  // change flags cleared by status read
  ums_modem_detect ums_modem_detect_inst (
    .mclk(mclk),
    .rst_b(rst_b),
    .ce(ce),
    .lvl(msr_lvl),
    .rd_clr(rd_msr),
    .delta(delta)
  );

  // ---- line status ----
  // count of erroneous characters held
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      err_cnt_r <= '0;
    end else if (ce) begin
      if (rx_fifo_clear) begin
        err_cnt_r <= '0;
      end else begin
        unique case ({rx_push && rx_push_err, rd_rx && rx_not_empty && (|rx_head_err)})
          2'b10: err_cnt_r <= err_cnt_r + CNT_W'(1);
          2'b01: err_cnt_r <= err_cnt_r - CNT_W'(1);
          2'b00, 2'b11: err_cnt_r <= err_cnt_r;
        endcase
      end
    end
  end

  // empty read poisons summary until fifo clear
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      empty_rd_r <= 1'b0;
    end else if (ce) begin
      if (rd_rx && !rx_not_empty) begin
        empty_rd_r <= 1'b1;
      end else if (rx_fifo_clear) begin
        empty_rd_r <= 1'b0;
      end
    end
  end

  assign lsr_err_sum = (err_cnt_r != '0) | empty_rd_r;
  // head error bits not stored here
  assign lsr_val = {lsr_err_sum, tx_all_empty, thr_empty, rx_head_err.brk,
                    rx_head_err.frm, rx_head_err.par, rx_overrun, rx_not_empty};

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rx_pop <= 1'b0;
      tx_push <= 1'b0;
    end else if (ce) begin
      rx_pop <= rd_rx & rx_not_empty;
      tx_push <= wr_tx;
    end
  end

  // ---- interrupt enable ----
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ier_r <= `UMS_IE_RESET;
    end else if (wr_ier) begin
      ier_r[3:0] <= wdata[3:0];
      if (enh_en) begin
        ier_r[7:4] <= wdata[7:4];
      end
    end
  end

  // transmit empty pending only from a fresh empty edge
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      thr_empty_q_r <= 1'b1;
      txe_pend_r <= 1'b0;
    end else if (ce) begin
      thr_empty_q_r <= thr_empty;
      if (thr_empty && !thr_empty_q_r) begin
        txe_pend_r <= 1'b1;
      end else if (wr_tx || (rd_iid && iid == UMS_IID_TXE)) begin
        txe_pend_r <= 1'b0;
      end else if (wr_ier && !ier_r[`UMS_IE_TX_EMPTY] && wdata[`UMS_IE_TX_EMPTY]) begin
        txe_pend_r <= 1'b0;
      end
    end
  end

  // flow event flags, set beats identification read
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      xoff_pend_r <= 1'b0;
      flow_pend_r <= 1'b0;
    end else if (ce) begin
      if (int_src.xoff_seen) begin
        xoff_pend_r <= 1'b1;
      end else if (rd_iid && iid == UMS_IID_XOFF) begin
        xoff_pend_r <= 1'b0;
      end
      if ((int_src.cts_rise && ier_r[`UMS_IE_CTS]) || (int_src.rts_rise && ier_r[`UMS_IE_RTS])) begin
        flow_pend_r <= 1'b1;
      end else if (rd_iid && iid == UMS_IID_FLOW) begin
        flow_pend_r <= 1'b0;
      end
    end
  end

  // ---- priority ----
  assign pend[0] = ier_r[`UMS_IE_LINE] & (rx_overrun | (rx_not_empty & (|rx_head_err)));
  assign pend[1] = ier_r[`UMS_IE_RX_DATA] & int_src.rx_timeout;
  assign pend[2] = ier_r[`UMS_IE_RX_DATA] & int_src.rx_data;
  assign pend[3] = ier_r[`UMS_IE_TX_EMPTY] & txe_pend_r;
  assign pend[4] = ier_r[`UMS_IE_MODEM] & (|delta);
  assign pend[5] = ier_r[`UMS_IE_XOFF] & xoff_pend_r;
  assign pend[6] = flow_pend_r;

  always_comb begin
    if (pend[0]) begin
      iid = UMS_IID_LINE;
    end else if (pend[1]) begin
      iid = UMS_IID_RXTO;
    end else if (pend[2]) begin
      iid = UMS_IID_RXDAT;
    end else if (pend[3]) begin
      iid = UMS_IID_TXE;
    end else if (pend[4]) begin
      iid = UMS_IID_MODEM;
    end else if (pend[5]) begin
      iid = UMS_IID_XOFF;
    end else if (pend[6]) begin
      iid = UMS_IID_FLOW;
    end else begin
      iid = UMS_IID_NONE;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |pend;
    end
  end

  // ---- read data ----
  // hold last read so slow hosts can sample late
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= `UMS_RD_RESET;
    end else if (ce && rd_stb) begin
      if (!std_bank) begin
        rdata <= 8'h00;
      end else begin
        unique case (addr)
          `UMS_A_INT_EN: rdata <= ier_r;
          `UMS_A_INT_ID: rdata <= {fifo_en, fifo_en, iid};
          `UMS_A_MODEM_CTL: rdata <= mcr_r;
          `UMS_A_LINE_STAT: rdata <= lsr_val;
          `UMS_A_MODEM_STAT: rdata <= {msr_lvl, delta};
          default: rdata <= 8'h00;
        endcase
      end
    end
  end

  // ---- checks ----
  chk_head_err_direct: assert property (@(posedge mclk) disable iff (!rst_b)
    ce && rd_stb && hit(addr, `UMS_A_LINE_STAT, std_bank) |=> rdata[4:2] == $past(rx_head_err))
    else $error("line status head bits wrong");
  chk_lsr_no_pop: assert property (@(posedge mclk) disable iff (!rst_b)
    ce && rd_stb && !hit(addr, `UMS_A_RX_TX, std_bank) |=> !rx_pop)
    else $error("fifo popped by non holding read");
  chk_empty_sticky: assert property (@(posedge mclk) disable iff (!rst_b)
    empty_rd_r && !rx_fifo_clear |=> lsr_err_sum)
    else $error("empty read error lost");
  chk_dtr_drive: assert property (@(posedge mclk) disable iff (!rst_b)
    ce && !mcr_r[`UMS_MC_LOOP] ##1 1'b1 |-> dtr_b == !$past(mcr_r[`UMS_MC_DTR]))
    else $error("dtr pin not following control");
  chk_loop_status: assert property (@(posedge mclk) disable iff (!rst_b)
    mcr_r[`UMS_MC_LOOP] |-> msr_lvl == {mcr_r[3], mcr_r[2], mcr_r[0], mcr_r[1]})
    else $error("loopback status mismatch");
  chk_enh_protect: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_mcr && !enh_en && rst_seen_r |=> mcr_r[7:5] == $past(mcr_r[7:5]))
    else $error("protected control bits written");
  chk_ier_protect: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_ier && !enh_en |=> ier_r[7:4] == $past(ier_r[7:4]))
    else $error("protected enable bits written");
  chk_irq_follow: assert property (@(posedge mclk) disable iff (!rst_b)
    ce && (iid != UMS_IID_NONE) |=> irq)
    else $error("interrupt not raised");
  chk_line_first: assert property (@(posedge mclk) disable iff (!rst_b)
    pend[0] |-> iid == UMS_IID_LINE)
    else $error("line status not top priority");
  chk_txe_rearm: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_ier && !ier_r[1] && wdata[1] && !(thr_empty && !thr_empty_q_r) |=> !txe_pend_r)
    else $error("transmit empty raised on re-enable");

  cov_loopback: cover property (@(posedge mclk) disable iff (!rst_b)
    mcr_r[`UMS_MC_LOOP] && wr_mcr && wdata[`UMS_MC_RTS]);
  cov_modem_irq: cover property (@(posedge mclk) disable iff (!rst_b)
    iid == UMS_IID_MODEM ##1 rd_msr);
  cov_err_drain: cover property (@(posedge mclk) disable iff (!rst_b)
    err_cnt_r == CNT_W'(1) ##1 err_cnt_r == '0);

endmodule : ums_regs

// file: tb/ums_host_model.sv
// host processor model driving the 8-bit register bus of the status block
`timescale 1ns/1ps
module ums_host_model (
  input wire logic mclk,
  output logic [2:0] addr,
  output logic rd_stb,
  output logic wr_stb,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  initial begin
    addr = 3'h0;
    rd_stb = 1'b0;
    wr_stb = 1'b0;
    wdata = 8'h00;
  end

  // one-cycle write strobe, data held through the taking edge
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
    // released bus shows the inverse, never a stale copy
    wdata <= ~d;
  endtask : reg_wr

  // empty fifo read only when asked
  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask : reg_rd
endmodule : ums_host_model

// file: tb/ums_regs_tb_top.sv
// self-checking bench for the modem control, status and interrupt registers
`timescale 1ns/1ps
`include "ums_defines.svh"
module ums_regs_tb_top;
  import ums_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1, std_bank = 1'b1, enh_en = 1'b0, fifo_en = 1'b1, auto_rts_en = 1'b0, flow_rts_b = 1'b1;
  logic rx_not_empty = 1'b0, rx_overrun = 1'b0, rx_push = 1'b0, rx_push_err = 1'b0, rx_fifo_clear = 1'b0;
  logic thr_empty = 1'b0, tx_all_empty = 1'b0, sel_pin = 1'b0, tx_serial = 1'b1, rx_pin = 1'b1;
  logic cts_b = 1'b1, dsr_b = 1'b1, ri_b = 1'b1, cd_b = 1'b1;
  ums_head_err_s rx_head_err = '0;
  ums_int_src_s int_src = '0;
  logic [2:0] addr;
  logic rd_stb, wr_stb, rx_pop, tx_push, dtr_b, rts_b, tx_pin, rx_serial, irq, irq_oe;
  logic fifo_ready_en, xon_any_en, thresh_access_en, prescale_div4, loopback;
  logic [7:0] wdata, rdata, d;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;

  initial begin
    forever #20 mclk = ~mclk;
  end

  ums_host_model ums_host_model_inst (.mclk(mclk), .addr(addr), .rd_stb(rd_stb), .wr_stb(wr_stb),
    .wdata(wdata), .rdata(rdata));

  ums_regs ums_regs_inst (.mclk(mclk), .rst_b(rst_b), .ce(ce), .addr(addr), .std_bank(std_bank),
    .rd_stb(rd_stb), .wr_stb(wr_stb), .wdata(wdata), .rdata(rdata), .rx_pop(rx_pop), .tx_push(tx_push),
    .enh_en(enh_en), .fifo_en(fifo_en), .auto_rts_en(auto_rts_en), .flow_rts_b(flow_rts_b),
    .rx_not_empty(rx_not_empty), .rx_overrun(rx_overrun), .rx_head_err(rx_head_err), .rx_push(rx_push),
    .rx_push_err(rx_push_err), .rx_fifo_clear(rx_fifo_clear), .thr_empty(thr_empty),
    .tx_all_empty(tx_all_empty), .int_src(int_src), .clock_prescale_select_pin(sel_pin),
    .cts_b(cts_b), .dsr_b(dsr_b), .ri_b(ri_b), .cd_b(cd_b), .dtr_b(dtr_b), .rts_b(rts_b),
    .tx_serial(tx_serial), .rx_pin(rx_pin), .tx_pin(tx_pin), .rx_serial(rx_serial), .irq(irq),
    .irq_oe(irq_oe), .fifo_ready_en(fifo_ready_en), .xon_any_en(xon_any_en),
    .thresh_access_en(thresh_access_en), .prescale_div4(prescale_div4), .loopback(loopback));

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask : idle

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    ums_host_model_inst.reg_wr(a, v);
  endtask : wr

  task automatic rd_chk(input string name, input logic [2:0] a, input logic [7:0] exp);
    ums_host_model_inst.reg_rd(a, d);
    check(name, d, exp);
  endtask : rd_chk

  task automatic t_reset_vals;
    rd_chk("mcr_reset", `UMS_A_MODEM_CTL, 8'h80);
    rd_chk("ier_reset", `UMS_A_INT_EN, 8'h00);
    check("pins_reset", {4'h0, dtr_b, rts_b, irq, irq_oe}, 8'h0c);
    rd_chk("unmapped", 3'h3, 8'h00);
    // a write while the clock enable is low must leave no trace
    ce <= 1'b0;
    wr(`UMS_A_INT_EN, 8'h0f);
    ce <= 1'b1;
    rd_chk("ce_freeze", `UMS_A_INT_EN, 8'h00);
  endtask : t_reset_vals

  task automatic t_modem_ctl;
    wr(`UMS_A_MODEM_CTL, 8'hff);
    rd_chk("mcr_locked", `UMS_A_MODEM_CTL, 8'h9f);
    idle(2);
    ums_host_model_inst.reg_rd(`UMS_A_MODEM_STAT, d);
    check("msr_loop_hi", {4'h0, d[7:4]}, 8'h0f);
    check("loop_outs", {3'h0, tx_pin, dtr_b, rts_b, irq_oe, fifo_ready_en}, 8'h1e);
    check("mode_bits", {4'h0, loopback, xon_any_en, thresh_access_en, prescale_div4}, 8'h09);
    @(posedge mclk);
    tx_serial <= 1'b0;
    idle(2);
    check("rx_loop", {7'h0, rx_serial}, 8'h00);
    enh_en <= 1'b1;
    wr(`UMS_A_MODEM_CTL, 8'h67);
    idle(2);
    check("norm_outs", {4'h0, dtr_b, rts_b, fifo_ready_en, prescale_div4}, 8'h02);
    check("enh_modes", {6'h0, xon_any_en, thresh_access_en}, 8'h03);
    rd_chk("mcr_enh", `UMS_A_MODEM_CTL, 8'h67);
    auto_rts_en <= 1'b1;
    idle(2);
    check("auto_rts", {7'h0, rts_b}, 8'h01);
    auto_rts_en <= 1'b0;
    tx_serial <= 1'b1;
    enh_en <= 1'b0;
    wr(`UMS_A_MODEM_CTL, 8'h03);
    idle(3);
    ums_host_model_inst.reg_rd(`UMS_A_MODEM_STAT, d);
  endtask : t_modem_ctl

  task automatic t_modem_delta;
    @(posedge mclk);
    cts_b <= 1'b0;
    idle(3);
    rd_chk("msr_delta", `UMS_A_MODEM_STAT, 8'h11);
    rd_chk("msr_cleared", `UMS_A_MODEM_STAT, 8'h10);
    // dsr change lands on the very edge that takes the status read
    fork
      ums_host_model_inst.reg_rd(`UMS_A_MODEM_STAT, d);
      begin
        @(posedge mclk);
        dsr_b <= 1'b0;
      end
    join
    check("msr_race_rd", d, 8'h30);
    rd_chk("msr_race_keep", `UMS_A_MODEM_STAT, 8'h32);
  endtask : t_modem_delta

  task automatic t_line;
    @(posedge mclk);
    rx_head_err <= 3'b101;
    rx_not_empty <= 1'b1;
    rx_push <= 1'b1;
    rx_push_err <= 1'b1;
    @(posedge mclk);
    rx_push <= 1'b0;
    rx_push_err <= 1'b0;
    idle(2);
    rd_chk("lsr_err", `UMS_A_LINE_STAT, 8'h95);
    check("no_pop_lsr", {7'h0, rx_pop}, 8'h00);
    rd_chk("rhr_read", `UMS_A_RX_TX, 8'h00);
    check("pop_rhr", {7'h0, rx_pop}, 8'h01);
    rx_head_err <= 3'b000;
    rx_not_empty <= 1'b0;
    idle(2);
    rd_chk("lsr_clean", `UMS_A_LINE_STAT, 8'h00);
    ums_host_model_inst.reg_rd(`UMS_A_RX_TX, d);
    check("no_pop_empty", {7'h0, rx_pop}, 8'h00);
    idle(2);
    rd_chk("lsr_empty_rd", `UMS_A_LINE_STAT, 8'h80);
    rx_fifo_clear <= 1'b1;
    @(posedge mclk);
    rx_fifo_clear <= 1'b0;
    idle(2);
    rd_chk("lsr_fifo_clr", `UMS_A_LINE_STAT, 8'h00);
    wr(`UMS_A_RX_TX, 8'h5a);
    #1;
    check("tx_push", {7'h0, tx_push}, 8'h01);
  endtask : t_line

  task automatic iid(input string name, input logic [7:0] exp, input logic irq_exp);
    idle(3);
    check({name, "_irq"}, {7'h0, irq}, {7'h0, irq_exp});
    rd_chk(name, `UMS_A_INT_ID, exp);
  endtask : iid

  task automatic t_irq;
    wr(`UMS_A_INT_EN, 8'hff);
    rd_chk("ier_locked", `UMS_A_INT_EN, 8'h0f);
    rx_overrun <= 1'b1;
    int_src.rx_data <= 1'b1;
    iid("iid_line", 8'hc6, 1'b1);
    rx_overrun <= 1'b0;
    iid("iid_rxdat", 8'hc4, 1'b1);
    int_src.rx_data <= 1'b0;
    int_src.rx_timeout <= 1'b1;
    iid("iid_rxto", 8'hcc, 1'b1);
    int_src.rx_timeout <= 1'b0;
    thr_empty <= 1'b1;
    iid("iid_txe", 8'hc2, 1'b1);
    iid("iid_none", 8'hc1, 1'b0);
    wr(`UMS_A_INT_EN, 8'h0d);
    // fresh empty edge while disabled must not survive the re-enable
    thr_empty <= 1'b0;
    idle(2);
    thr_empty <= 1'b1;
    idle(2);
    wr(`UMS_A_INT_EN, 8'h0f);
    iid("iid_rearm", 8'hc1, 1'b0);
    cd_b <= 1'b0;
    iid("iid_modem", 8'hc0, 1'b1);
    ums_host_model_inst.reg_rd(`UMS_A_MODEM_STAT, d);
    iid("iid_msr_clr", 8'hc1, 1'b0);
    enh_en <= 1'b1;
    wr(`UMS_A_INT_EN, 8'hef);
    rd_chk("ier_enh", `UMS_A_INT_EN, 8'hef);
    int_src.xoff_seen <= 1'b1;
    @(posedge mclk);
    int_src.xoff_seen <= 1'b0;
    iid("iid_xoff", 8'hd0, 1'b1);
    int_src.cts_rise <= 1'b1;
    @(posedge mclk);
    int_src.cts_rise <= 1'b0;
    iid("iid_flow", 8'he0, 1'b1);
    fifo_en <= 1'b0;
    iid("iid_nofifo", 8'h01, 1'b0);
  endtask : t_irq

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // ceiling well above the roughly 150 cycles the scenarios need
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      $display("[ERR] timeout expected end seen hang");
      final_report;
    end
  end

  initial begin
    idle(3);
    rst_b <= 1'b1;
    idle(2);
    t_reset_vals;
    t_modem_ctl;
    t_modem_delta;
    t_line;
    t_irq;
    final_report;
  end
endmodule : ums_regs_tb_top
